// ==== hw/spicsr_dev.sv ====
// Purpose: device end, control and status space of the programming link
// Assumes: instruction byte then data byte(s) arrive on the link strobes
// Notes: guard idle is counted in core clocks, four per link bit
// How it works
// - control space reached only by dedicated instructions
// - offset 0x0F returns identification code
// - offset 0x02 bits 2:0 select guard time
// - guard idle only on receive-to-transmit turn
// - turnaround idle equals guard plus two bits
// - guard code resets to 000, 128 bits
// - programmer sets shortest safe guard time; host stores whatever guard code the user's store request gives
// - status bit 1 shows programming enabled
// - programmer polls enabled flag before programming; host reads status only when the user requests a load
// - writing zero to flag disables programming
// - load 1000aaaa, store 1100aaaa decoded
// - flag set only after key plus eight bytes
`timescale 1ns/1ns
`include "spicsr_cfg.svh"
module spicsr_dev
    import spicsr_pkg::*;
#(
    parameter spicsr_byte_t IDENT = `SPICSR_IDENT_CODE  // arbitrary value
)
(
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst,
    // link
    spicsr_if.dev       lnk,
    // user side
    output logic        nvm_prog_enabled,
    output spicsr_gt_t  guard_time_code
);
    typedef enum logic [1:0] {DV_IDLE, DV_DATA, DV_KEY, DV_TURN} spicsr_dst_e;

    spicsr_dst_e        st_q, st_d;
    logic               key_ok;
    spicsr_addr_t       addr_q, addr_d;
    spicsr_gt_t         gt_q, gt_d;
    logic               en_q, en_d;
    logic [63:0]        key_q, key_d;
    logic [3:0]         kcnt_q, kcnt_d;
    logic [9:0]         turn_q, turn_d;
    spicsr_byte_t       rsp_q, rsp_d;
    logic               rv_q, rv_d;

    function automatic spicsr_byte_t rd_css(
        input spicsr_addr_t a,
        input spicsr_gt_t   g,
        input logic         e
    );
        spicsr_byte_t r;
        r = 8'h00;
        unique case (a)
            `SPICSR_OFF_IDENT:  r = IDENT;
            `SPICSR_OFF_PHYCTL: r = {5'h00, g};
            `SPICSR_OFF_STATUS: r = {6'h00, e, 1'b0};
            default:            r = 8'h00;
        endcase
        return r;
    endfunction

    // guard idle bits, halving per code, none for the last
    function automatic logic [7:0] guard_bits(input spicsr_gt_t g);
        logic [7:0] bits;
        if (g == `SPICSR_GT_NONE)
            bits = 8'h00;
        else
            bits = 8'(`SPICSR_GT_MAX_BITS >> g);
        return bits;
    endfunction

    // turnaround in core clocks, guard plus two idle bits
    function automatic logic [9:0] turn_cycles(input spicsr_gt_t g);
        logic [9:0] idle_bits;
        idle_bits = 10'({2'b00, guard_bits(g)} + 10'(`SPICSR_BASE_IDLE));
        return 10'(idle_bits * 10'(`SPICSR_BIT_DIV));
    endfunction

    // key checked on the word as it stands after this byte
    assign key_ok = ({lnk.dat_byte, key_q[63:8]} == `SPICSR_ENABLE_KEY);

    always_comb
    begin
        st_d   = st_q;
        addr_d = addr_q;
        gt_d   = gt_q;
        en_d   = en_q;
        key_d  = key_q;
        kcnt_d = kcnt_q;
        turn_d = turn_q;
        rsp_d  = rsp_q;
        rv_d   = 1'b0;
        unique case (st_q)
            DV_IDLE:
            begin
                if (lnk.cmd_valid)
                begin
                    addr_d = lnk.cmd_byte[3:0];
                    if (lnk.cmd_byte[7:4] == `SPICSR_OP_LOAD)
                    begin
                        rsp_d  = rd_css(lnk.cmd_byte[3:0], gt_q, en_q);
                        turn_d = turn_cycles(gt_q);
                        st_d   = DV_TURN;
                    end
                    // store waits for its data byte
                    else if (lnk.cmd_byte[7:4] == `SPICSR_OP_STORE)
                    begin
                        st_d = DV_DATA;
                    end
                    // key waits for eight data bytes
                    else if (lnk.cmd_byte == `SPICSR_OP_KEY)
                    begin
                        kcnt_d = 4'h0;
                        st_d   = DV_KEY;
                    end
                end
            end

            DV_DATA:
            begin
                if (lnk.dat_valid)
                begin
                    if (addr_q == `SPICSR_OFF_PHYCTL)
                        gt_d = lnk.dat_byte[2:0];
                    else if (addr_q == `SPICSR_OFF_STATUS && !lnk.dat_byte[`SPICSR_EN_BIT])
                        en_d = 1'b0;
                    st_d = DV_IDLE;
                end
            end

            DV_KEY:
            begin
                if (lnk.dat_valid)
                begin
                    key_d  = {lnk.dat_byte, key_q[63:8]};
                    kcnt_d = 4'(kcnt_q + 4'h1);
                    if (kcnt_q == 4'(`SPICSR_KEY_BYTES - 4'h1))
                    begin
                        if (key_ok)
                            en_d = 1'b1;
                        st_d = DV_IDLE;
                    end
                end
            end

            DV_TURN:
            begin
                if (turn_q == 10'h000)
                begin
                    rv_d = 1'b1;
                    st_d = DV_IDLE;
                end
                else
                    turn_d = 10'(turn_q - 10'h001);
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_q   <= DV_IDLE;
            addr_q <= 4'h0;
            gt_q   <= `SPICSR_GT_RESET;
            en_q   <= 1'b0;
            key_q  <= 64'h0;
            kcnt_q <= 4'h0;
            turn_q <= 10'h000;
            rsp_q  <= 8'h00;
            rv_q   <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            addr_q <= addr_d;
            gt_q   <= gt_d;
            en_q   <= en_d;
            key_q  <= key_d;
            kcnt_q <= kcnt_d;
            turn_q <= turn_d;
            rsp_q  <= rsp_d;
            rv_q   <= rv_d;
        end
    end

    assign lnk.rsp_valid   = rv_q;
    assign lnk.rsp_byte    = rsp_q;
    assign lnk.link_busy   = (st_q == DV_TURN);

    // line idles high during turnaround and the answer cycle, released otherwise
    assign lnk.line_dev_o  = 1'b1;
    assign lnk.line_dev_oe = (st_q == DV_TURN) || rv_q;

    assign nvm_prog_enabled = en_q;
    assign guard_time_code  = gt_q;
endmodule

// ==== pkg/spicsr_cfg.svh ====
// Purpose: constants of the programming interface control space
// Assumes: one clock, synchronous reset
// Notes: offsets are 4-bit control-space addresses
`ifndef SPICSR_CFG_SVH
`define SPICSR_CFG_SVH
`define SPICSR_OFF_STATUS     4'h0
`define SPICSR_OFF_PHYCTL     4'h2
`define SPICSR_OFF_IDENT      4'hf
`define SPICSR_OP_LOAD        4'h8
`define SPICSR_OP_STORE       4'hc
`define SPICSR_OP_KEY         8'he0
`define SPICSR_KEY_BYTES      4'h8
`define SPICSR_ENABLE_KEY     64'h1289ab45cdd888ff
`define SPICSR_IDENT_CODE     8'h5a
`define SPICSR_EN_BIT         1
`define SPICSR_GT_RESET       3'h0
`define SPICSR_GT_NONE        3'h7
`define SPICSR_GT_MAX_BITS    8'h80
`define SPICSR_BASE_IDLE      8'h02
`define SPICSR_BIT_DIV        4'h4
`endif

// ==== pkg/spicsr_pkg.sv ====
// Purpose: shared types of the programming interface control space
// Assumes: cfg header holds the numbers
// Notes: none
package spicsr_pkg;
    typedef logic [7:0] spicsr_byte_t;
    typedef logic [3:0] spicsr_addr_t;
    typedef logic [2:0] spicsr_gt_t;
    typedef enum logic [1:0] {SPICSR_OP_NONE, SPICSR_OP_LD, SPICSR_OP_ST, SPICSR_OP_KEY_SIGNAL_INSTRUCTION}
        spicsr_op_e;
endpackage

// ==== pkg/spicsr_if.sv ====
// Purpose: link between programmer and device control space
// Assumes: byte-level instruction link, one clock
// Notes: only the device drives the data line, through line_dev_o and line_dev_oe
`timescale 1ns/1ns
interface spicsr_if;
    import spicsr_pkg::*;
    logic               cmd_valid;
    spicsr_byte_t       cmd_byte;
    logic               dat_valid;
    spicsr_byte_t       dat_byte;
    logic               rsp_valid;
    spicsr_byte_t       rsp_byte;
    logic               link_busy;
    logic               line_dev_o;
    logic               line_dev_oe;
    modport dev  (input cmd_valid, cmd_byte, dat_valid, dat_byte,
                  output rsp_valid, rsp_byte, link_busy, line_dev_o, line_dev_oe);
    modport host (output cmd_valid, cmd_byte, dat_valid, dat_byte,
                  input rsp_valid, rsp_byte, link_busy, line_dev_o, line_dev_oe);
endinterface

// ==== hw/spicsr_host.sv ====
// Purpose: programmer end issuing control space instructions
// Assumes: user gives one request at a time while ready
// Notes: keeps device rules on the far side
`timescale 1ns/1ns
`include "spicsr_cfg.svh"
module spicsr_host
    import spicsr_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // link
    spicsr_if.host           lnk,
    // user requests
    input  wire logic        req_valid,
    input  spicsr_op_e       req_op,
    input  spicsr_addr_t     req_addr,
    input  spicsr_byte_t     req_data,
    input  wire logic [63:0] req_key,
    output logic             req_ready,
    // user results
    output logic             rd_valid,
    output spicsr_byte_t     rd_data
);
    typedef enum logic [1:0] {HS_IDLE, HS_DATA, HS_WAIT} spicsr_hst_e;

    spicsr_hst_e        st_q, st_d;
    logic               cv_q, cv_d;
    spicsr_byte_t       cb_q, cb_d;
    logic               dv_q, dv_d;
    spicsr_byte_t       db_q, db_d;
    logic [63:0]        sh_q, sh_d;
    logic [3:0]         left_q, left_d;
    logic               rv_q, rv_d;
    spicsr_byte_t       rd_q, rd_d;

    always_comb
    begin
        st_d   = st_q;
        cv_d   = 1'b0;
        cb_d   = cb_q;
        dv_d   = 1'b0;
        db_d   = db_q;
        sh_d   = sh_q;
        left_d = left_q;
        rv_d   = 1'b0;
        rd_d   = rd_q;
        unique case (st_q)
            HS_IDLE:
            begin
                if (req_valid)
                begin
                    cv_d = 1'b1;
                    unique case (req_op)
                        SPICSR_OP_LD:
                        begin
                            cb_d = {`SPICSR_OP_LOAD, req_addr};
                            st_d = HS_WAIT;
                        end
                        SPICSR_OP_ST:
                        begin
                            cb_d   = {`SPICSR_OP_STORE, req_addr};
                            sh_d   = {56'h0, req_data};
                            left_d = 4'h1;
                            st_d   = HS_DATA;
                        end
                        SPICSR_OP_KEY_SIGNAL_INSTRUCTION:
                        begin
                            cb_d   = `SPICSR_OP_KEY;
                            sh_d   = req_key;
                            left_d = `SPICSR_KEY_BYTES;
                            st_d   = HS_DATA;
                        end
                        default:
                            cv_d = 1'b0;
                    endcase
                end
            end
            HS_DATA:
            begin
                dv_d   = 1'b1;
                db_d   = sh_q[7:0];
                sh_d   = {8'h00, sh_q[63:8]};
                left_d = 4'(left_q - 4'h1);
                if (left_q == 4'h1)
                    st_d = HS_IDLE;
            end
            HS_WAIT:
            begin
                if (lnk.rsp_valid)
                begin
                    rv_d = 1'b1;
                    rd_d = lnk.rsp_byte;
                    st_d = HS_IDLE;
                end
            end
            default:
                st_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_q   <= HS_IDLE;
            cv_q   <= 1'b0;
            cb_q   <= 8'h00;
            dv_q   <= 1'b0;
            db_q   <= 8'h00;
            sh_q   <= 64'h0;
            left_q <= 4'h0;
            rv_q   <= 1'b0;
            rd_q   <= 8'h00;
        end
        else
        begin
            st_q   <= st_d;
            cv_q   <= cv_d;
            cb_q   <= cb_d;
            dv_q   <= dv_d;
            db_q   <= db_d;
            sh_q   <= sh_d;
            left_q <= left_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
        end
    end

    assign lnk.cmd_valid = cv_q;
    assign lnk.cmd_byte  = cb_q;
    assign lnk.dat_valid = dv_q;
    assign lnk.dat_byte  = db_q;
    assign req_ready     = (st_q == HS_IDLE) && !cv_q && !dv_q;
    assign rd_valid      = rv_q;
    assign rd_data       = rd_q;
endmodule

// ==== sim/spicsr_props.sv ====
// Purpose: link checks for the control space
// Assumes: one clock, rst synchronous active high
// Notes: guard code tracked from stores seen on the link
`timescale 1ns/1ns
module spicsr_props
    import spicsr_pkg::*;
#(
    parameter spicsr_byte_t IDENT = 8'h00  // arbitrary value
)
(
    // clock and reset
    input wire logic     core_clk,
    input wire logic     rst,
    // link
    input wire logic     cmd_valid,
    input spicsr_byte_t  cmd_byte,
    input wire logic     dat_valid,
    input spicsr_byte_t  dat_byte,
    input wire logic     rsp_valid,
    input spicsr_byte_t  rsp_byte,
    input wire logic     link_busy,
    input wire logic     line_dev_o,
    input wire logic     line_dev_oe
);
    spicsr_gt_t   gt_q, gt_d;
    logic         pend_q, pend_d, wait_q, wait_d, ans;
    spicsr_addr_t addr_q, addr_d;
    logic [9:0]   cnt_q, cnt_d, exp_q, exp_d;
    assign ans = rsp_valid && wait_q;
    always_comb
    begin
        gt_d = gt_q;
        pend_d = pend_q;
        wait_d = wait_q && !rsp_valid;
        addr_d = addr_q;
        cnt_d = cnt_q + 10'h1;
        exp_d = exp_q;
        if (cmd_valid)
            pend_d = (cmd_byte == 8'hc2);
        if (dat_valid && pend_q)
        begin
            gt_d = dat_byte[2:0];
            pend_d = 1'b0;
        end
        if (cmd_valid && cmd_byte[7:4] == 4'h8)
        begin
            wait_d = 1'b1;
            addr_d = cmd_byte[3:0];
            cnt_d = 10'h1;
            exp_d = (gt_q == 3'h7) ? 10'ha : ((10'h80 >> gt_q) + 10'h2) * 10'h4 + 10'h2;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            gt_q <= 3'h0;
            pend_q <= 1'b0;
            wait_q <= 1'b0;
            addr_q <= 4'h0;
            cnt_q <= 10'h0;
            exp_q <= 10'h0;
        end
        else
        begin
            gt_q <= gt_d;
            pend_q <= pend_d;
            wait_q <= wait_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end
    sequence s_load;
        cmd_valid && cmd_byte[7:4] == 4'h8;
    endsequence
    sequence s_store;
        cmd_valid && cmd_byte[7:4] == 4'hc;
    endsequence
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_busy_on_load: assert property (s_load |=> link_busy && line_dev_oe && line_dev_o)
        else $error("no turnaround after load");
    a_busy_hold: assert property (s_load |=> link_busy [*8])
        else $error("turnaround shorter than two bits");
    a_turn_count: assert property (rsp_valid |-> wait_q && cnt_q == exp_q)
        else $error("answer at wrong cycle");
    a_no_turn_store: assert property (s_store |=> !link_busy [*3])
        else $error("turnaround after store");
    a_busy_cause: assert property (link_busy |-> wait_q)
        else $error("busy without load");
    a_ident_code: assert property (ans && addr_q == 4'hf |-> rsp_byte == IDENT)
        else $error("wrong identification code");
    a_phy_readback: assert property (ans && addr_q == 4'h2 |-> rsp_byte == {5'h00, gt_q})
        else $error("guard field readback wrong");
    a_rsvd_zero: assert property (ans && !(addr_q inside {4'h0, 4'h2, 4'hf})
        |-> rsp_byte == 8'h00)
        else $error("reserved offset not zero");
endmodule

// ==== sim/tb_top.sv ====
// Purpose: both ends joined, driven from the host user port
// Assumes: rst synchronous active high, 25 MHz clock
// Notes: latency measured from the taken edge to rd_valid
`timescale 1ns/1ns
module tb_top;
    import spicsr_pkg::*;
    logic         core_clk, rst, req_valid, req_ready, rd_valid, nvm_prog_enabled;
    spicsr_op_e   req_op;
    spicsr_addr_t req_addr;
    spicsr_byte_t req_data, rd_data;
    logic [63:0]  req_key;
    spicsr_gt_t   guard_time_code, gt_cur;
    int           error_cnt, cmp_count;
    spicsr_if lnk_if ();
    spicsr_dev #(.IDENT(8'h5a)) i_spicsr_dev (.core_clk(core_clk), .rst(rst), .lnk(lnk_if),
        .nvm_prog_enabled(nvm_prog_enabled), .guard_time_code(guard_time_code));
    spicsr_host i_spicsr_host (.core_clk(core_clk), .rst(rst), .lnk(lnk_if),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .req_key(req_key), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));
    spicsr_props #(.IDENT(8'h5a)) i_spicsr_props (.core_clk(core_clk), .rst(rst),
        .cmd_valid(lnk_if.cmd_valid), .cmd_byte(lnk_if.cmd_byte),
        .dat_valid(lnk_if.dat_valid), .dat_byte(lnk_if.dat_byte),
        .rsp_valid(lnk_if.rsp_valid), .rsp_byte(lnk_if.rsp_byte),
        .link_busy(lnk_if.link_busy), .line_dev_o(lnk_if.line_dev_o),
        .line_dev_oe(lnk_if.line_dev_oe));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_byte(spicsr_byte_t got, spicsr_byte_t exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cyc(int got, int exp);
        cmp_count++;
        if (got != exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t latency %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic do_req(spicsr_op_e op, spicsr_addr_t a, spicsr_byte_t d, logic [63:0] k);
        int n;
        n = 0;
        @(negedge core_clk);
        while (req_ready !== 1'b1 && n < 3000)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 3000)
        begin
            error_cnt++;
            $display("MISMATCH %0t request not accepted", $time);
        end
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        req_key <= k;
        @(posedge core_clk);
        req_valid <= 1'b0;
    endtask
    task automatic read_chk(spicsr_addr_t a, spicsr_byte_t exp);
        int n;
        int bits;
        n = 0;
        bits = ((gt_cur == 3'h7) ? 0 : (128 >> gt_cur)) + 2;
        do_req(SPICSR_OP_LD, a, 8'h00, 64'h0);
        while (rd_valid !== 1'b1 && n < 3000)
        begin
            @(negedge core_clk);
            n++;
        end
        chk_byte(rd_data, exp);
        chk_cyc(n - 1, 3 + bits * 4);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        {rst, req_valid, req_op, req_addr, req_data, req_key} = '0;
        rst = 1'b1;
        {error_cnt, cmp_count, gt_cur} = '0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk_byte({5'h00, guard_time_code}, 8'h00);
        read_chk(4'h0, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            do_req(SPICSR_OP_ST, 4'h2, {5'h1f, c[2:0]}, 64'h0);
            gt_cur = c[2:0];
            read_chk(4'h2, {5'h00, gt_cur});
            chk_byte({5'h00, guard_time_code}, {5'h00, gt_cur});
        end
        for (int a = 1; a < 15; a++)
        begin
            if (a != 2)
            begin
                do_req(SPICSR_OP_ST, a[3:0], 8'hff, 64'h0);
                read_chk(a[3:0], 8'h00);
            end
        end
        do_req(SPICSR_OP_ST, 4'h0, 8'hff, 64'h0);
        read_chk(4'h0, 8'h00);
        do_req(SPICSR_OP_KEY_SIGNAL_INSTRUCTION, 4'h0, 8'h00, 64'hff88d8cd45ab8912);
        read_chk(4'h0, 8'h00);
        do_req(SPICSR_OP_KEY_SIGNAL_INSTRUCTION, 4'h0, 8'h00, 64'h1289ab45cdd888fe);
        read_chk(4'h0, 8'h00);
        do_req(SPICSR_OP_KEY_SIGNAL_INSTRUCTION, 4'h0, 8'h00, 64'h1289ab45cdd888ff);
        read_chk(4'h0, 8'h02);
        chk_byte({7'h00, nvm_prog_enabled}, 8'h01);
        do_req(SPICSR_OP_ST, 4'h0, 8'h00, 64'h0);
        read_chk(4'h0, 8'h00);
        chk_byte({7'h00, nvm_prog_enabled}, 8'h00);
        do_req(SPICSR_OP_KEY_SIGNAL_INSTRUCTION, 4'h0, 8'h00, 64'h1289ab45cdd888ff);
        do_req(SPICSR_OP_ST, 4'h2, 8'h05, 64'h0);
        gt_cur = 3'h5;
        read_chk(4'hf, 8'h5a);
        chk_byte({7'h00, nvm_prog_enabled}, 8'h01);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        gt_cur = 3'h0;
        @(negedge core_clk);
        chk_byte({4'h0, nvm_prog_enabled, guard_time_code}, 8'h00);
        read_chk(4'h0, 8'h00);
        wrap_up();
    end
endmodule
